// ---- design/epc_regs.svh ----
// Purpose: Register indices, field positions, reset values and timing counts
// Assumes: Byte address on the bus is four times the register index
// Notes:   Definitions only
`ifndef EPC_REGS_SVH
`define EPC_REGS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define EPC_IDX_EXT_CTRL     8'h61
`define EPC_IDX_EXT_FLAGS    8'h62
`define EPC_IDX_EXT_MASK     8'h63
`define EPC_IDX_EXT_ACK      8'h65
`define EPC_IDX_OB_CTRL      8'h66
`define EPC_IDX_OB_FLAGS     8'h67
`define EPC_IDX_OB_MASK      8'h6A
`define EPC_IDX_PC_CTRL      8'h71
`define EPC_IDX_PC_FLAGS     8'h72
`define EPC_IDX_PC_MASK      8'h73
`define EPC_IDX_PL_PCMASK    8'h8F
`define EPC_IDX_KA_PCMASK    8'h93
`define EPC_IDX_KB_PCMASK    8'h97
`define EPC_IDX_KC_PCMASK    8'h9B
`define EPC_IDX_KD_PCMASK    8'h9F
`define EPC_IDX_EVT_STATUS   8'hA0
`define EPC_IDX_EVT_MASK     8'hA1

// ----------------------------------------------------------------------------
// Fields, reset values, timing
// ----------------------------------------------------------------------------
`define EPC_EXT_BITS         2
`define EPC_PC_BITS          6
`define EPC_PC_BIT_K         4
`define EPC_PC_BIT_PL        5
`define EPC_EVT_EXT          0
`define EPC_EVT_OB           2
`define EPC_EVT_PC           3
`define EPC_EVT_BITS         4
`define EPC_RESET_BYTE       8'h00
`define EPC_BUS_WAIT_CYCLES  1

`endif

// ---- design/epc_pkg.sv ----
// Purpose: Types shared by the interrupt aggregation block
// Assumes: Included header supplies the widths
// Notes:   State of the block is one packed struct
`include "epc_regs.svh"

package epc_pkg;

  // Bus answer phase
  typedef enum logic {EPC_BUS_IDLE, EPC_BUS_ANSWER} epc_bus_type;

  // Whole register state of the block
  typedef struct packed {
    epc_bus_type                     bus;        // Bus phase
    logic [31:0]                     rdata;      // Registered read data
    logic [`EPC_EXT_BITS-1:0]        ext_ctrl;   // Extended control
    logic [`EPC_EXT_BITS-1:0]        ext_flags;  // Extended flags
    logic [`EPC_EXT_BITS-1:0]        ext_mask;   // Extended mask
    logic [`EPC_EXT_BITS-1:0]        ext_ack;    // Extended acknowledge
    logic [7:0]                      ob_ctrl;    // Open-block control
    logic [7:0]                      ob_flags;   // Open-block flags
    logic [7:0]                      ob_mask;    // Open-block mask
    logic [`EPC_PC_BITS-1:0]         pc_ctrl;    // Port change control
    logic [`EPC_PC_BITS-1:0]         pc_flags;   // Port change flags
    logic [`EPC_PC_BITS-1:0]         pc_mask;    // Port change mask
    logic [7:0]                      pl_mask;    // PL pin mask
    logic [31:0]                     k_mask;     // KA..KD pin masks
    logic [7:0]                      pl_prev;    // Last PL pins
    logic [31:0]                     k_prev;     // Last K pins
    logic                            prev_ok;    // Pin history valid
    logic [`EPC_EVT_BITS-1:0]        evt_stat;   // Sticky event status
    logic [`EPC_EVT_BITS-1:0]        evt_mask;   // Event mask
  } epc_state_type;

endpackage

// ---- design/epc_irq_top.sv ----
// Purpose: Extended IRQ, open-block and port pin-change interrupt aggregation
// Assumes: Single clock; all inputs except RST_N synchronous to CLK
// Notes:   Avalon-MM slave, one wait state on every access
`timescale 1ns/1ps
`default_nettype none
`include "epc_regs.svh"

// Operation
// - Ext flag sets if source, mask, not acked
// - Ext flag clears on ack or source drop
// - Ext request needs flag and control bit
// - Delivered ext interrupt sets acknowledge bit
// - Writing one clears acknowledge bit
// - Open-block flag sets on masked notification
// - Open-block, port flags clear by write one
// - Open-block request needs flag and control
// - Port flag sets on masked group notification
// - Port request needs flag and control bit
// - Port bits: A,E,G,J,K,PL; top zero
module epc_irq_top
  import epc_pkg::*;
(
  input  wire logic         CLK,               // System clock, 250 MHz
  input  wire logic         RST_N,             // Async reset, active low
  input  wire logic [9:0]   AVS_ADDRESS,       // Byte address
  input  wire logic         AVS_READ,          // Read request
  input  wire logic         AVS_WRITE,         // Write request
  input  wire logic [31:0]  AVS_WRITEDATA,     // Write data
  input  wire logic [3:0]   AVS_BYTEENABLE,    // Byte lanes
  output logic [31:0]       AVS_READDATA,      // Read data
  output logic              AVS_WAITREQUEST,   // Stall
  input  wire logic [1:0]   EXT_IRQ_SRC,       // Group sources, level
  input  wire logic [1:0]   EXT_IRQ_TAKEN,     // Core took ext interrupt, pulse
  input  wire logic [7:0]   OPEN_BLOCK_NOTIFY, // Open-block notifications
  input  wire logic         PORT_A_NOTIFY,     // Port A change notice
  input  wire logic         PORT_E_NOTIFY,     // Port E change notice
  input  wire logic         PORT_G_NOTIFY,     // Port G change notice
  input  wire logic         PORT_J_NOTIFY,     // J group change notice
  input  wire logic [31:0]  PORT_K_PINS,       // KA..KD pin levels
  input  wire logic [7:0]   PORT_PL_PINS,      // PL pin levels
  output logic [1:0]        EXT_IRQ_REQ,       // Ext requests to core
  output logic [7:0]        OPEN_BLOCK_IRQ_REQ,// Open-block requests
  output logic [5:0]        PORT_CHANGE_IRQ_REQ,// Port change requests
  output logic              INT_OUT            // Summary interrupt, level
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  epc_state_type s_q;            // Registered state
  epc_state_type s_d;            // Next state
  logic [7:0]    idx;            // Register index
  logic          wr_go;          // Write takes effect this edge
  logic          rd_go;          // Read completes this edge
  logic [7:0]    wb;             // Written byte
  logic [3:0]    k_hit;          // Per K port masked change
  logic          pl_hit;         // PL masked change
  logic [5:0]    pc_notify;      // Group notifications
  logic [7:0]    cur_rd;         // Read value of addressed register

  assign idx = AVS_ADDRESS[9:2];
  assign wb  = AVS_WRITEDATA[7:0];

  // --------------------------------------------------------------------------
  // Decoding
  // --------------------------------------------------------------------------
  // Selects a register on a write that carries the low byte lane
  function automatic logic wsel(input logic [7:0] i);
    wsel = wr_go && AVS_BYTEENABLE[0] && (idx == i);
  endfunction

  // Read value of one register; unmapped reads as zero
  function automatic logic [7:0] rmux(input logic [7:0] i, input epc_state_type s);
    rmux = `EPC_RESET_BYTE;
    unique case (i)
      `EPC_IDX_EXT_CTRL:   rmux = {6'h00, s.ext_ctrl};
      `EPC_IDX_EXT_FLAGS:  rmux = {6'h00, s.ext_flags};
      `EPC_IDX_EXT_MASK:   rmux = {6'h00, s.ext_mask};
      `EPC_IDX_EXT_ACK:    rmux = {6'h00, s.ext_ack};
      `EPC_IDX_OB_CTRL:    rmux = s.ob_ctrl;
      `EPC_IDX_OB_FLAGS:   rmux = s.ob_flags;
      `EPC_IDX_OB_MASK:    rmux = s.ob_mask;
      `EPC_IDX_PC_CTRL:    rmux = {2'h0, s.pc_ctrl};
      `EPC_IDX_PC_FLAGS:   rmux = {2'h0, s.pc_flags};
      `EPC_IDX_PC_MASK:    rmux = {2'h0, s.pc_mask};
      `EPC_IDX_PL_PCMASK:  rmux = s.pl_mask;
      `EPC_IDX_KA_PCMASK:  rmux = s.k_mask[7:0];
      `EPC_IDX_KB_PCMASK:  rmux = s.k_mask[15:8];
      `EPC_IDX_KC_PCMASK:  rmux = s.k_mask[23:16];
      `EPC_IDX_KD_PCMASK:  rmux = s.k_mask[31:24];
      `EPC_IDX_EVT_STATUS: rmux = {4'h0, s.evt_stat};
      `EPC_IDX_EVT_MASK:   rmux = {4'h0, s.evt_mask};
      default:             rmux = `EPC_RESET_BYTE;
    endcase
  endfunction

  // Request is answered one cycle after it appears
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (s_q.bus == EPC_BUS_IDLE);
  assign wr_go = AVS_WRITE && (s_q.bus == EPC_BUS_ANSWER);
  assign rd_go = AVS_READ && (s_q.bus == EPC_BUS_ANSWER);
  assign cur_rd = rmux(idx, s_q);

  // --------------------------------------------------------------------------
  // Pin change detection
  // --------------------------------------------------------------------------
  // Each K port folds into one group bit; pins whose mask bit is zero are blind
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_kport
      assign k_hit[g] = s_q.prev_ok &&
        |((PORT_K_PINS[8*g+:8] ^ s_q.k_prev[8*g+:8]) & s_q.k_mask[8*g+:8]);
    end
  endgenerate

  assign pl_hit = s_q.prev_ok && |((PORT_PL_PINS ^ s_q.pl_prev) & s_q.pl_mask);

  // Group order A, E, G, J, K, PL
  assign pc_notify = {pl_hit, |k_hit, PORT_J_NOTIFY,
                      PORT_G_NOTIFY, PORT_E_NOTIFY, PORT_A_NOTIFY};

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic [1:0] ext_set;
    logic [7:0] ob_set;
    logic [5:0] pc_set;
    logic [1:0] ack_nx;
    ext_set = 2'h0;
    ob_set  = 8'h00;
    pc_set  = 6'h00;
    ack_nx  = 2'h0;
    s_d = s_q;

    // Bus phase: one wait cycle then answer
    if ((AVS_READ || AVS_WRITE) && s_q.bus == EPC_BUS_IDLE)
    begin
      s_d.bus   = EPC_BUS_ANSWER;
      s_d.rdata = {24'h000000, cur_rd};
    end
    else
    begin
      s_d.bus = EPC_BUS_IDLE;
    end

    // Plain read/write registers
    if (wsel(`EPC_IDX_EXT_CTRL))   s_d.ext_ctrl = wb[1:0];
    if (wsel(`EPC_IDX_EXT_MASK))   s_d.ext_mask = wb[1:0];
    if (wsel(`EPC_IDX_OB_CTRL))    s_d.ob_ctrl  = wb;
    if (wsel(`EPC_IDX_OB_MASK))    s_d.ob_mask  = wb;
    // Whole-byte writes only, so single-bit changes need read-modify-write
    if (wsel(`EPC_IDX_PC_CTRL))    s_d.pc_ctrl  = wb[5:0];
    if (wsel(`EPC_IDX_PC_MASK))    s_d.pc_mask  = wb[5:0];
    if (wsel(`EPC_IDX_PL_PCMASK))  s_d.pl_mask  = wb;
    if (wsel(`EPC_IDX_KA_PCMASK))  s_d.k_mask[7:0]   = wb;
    if (wsel(`EPC_IDX_KB_PCMASK))  s_d.k_mask[15:8]  = wb;
    if (wsel(`EPC_IDX_KC_PCMASK))  s_d.k_mask[23:16] = wb;
    if (wsel(`EPC_IDX_KD_PCMASK))  s_d.k_mask[31:24] = wb;
    if (wsel(`EPC_IDX_EVT_MASK))   s_d.evt_mask = wb[3:0];

    // Acknowledge: write one clears, delivery sets; the set wins
    ack_nx = s_q.ext_ack;
    if (wsel(`EPC_IDX_EXT_ACK))
      ack_nx = ack_nx & ~wb[1:0];
    ack_nx = ack_nx | (EXT_IRQ_TAKEN & s_q.ext_flags & s_q.ext_ctrl);
    s_d.ext_ack = ack_nx;

    // Ext flags follow the source level; an ack blocks and clears them.
    // Software clearing leaves the acknowledge until it writes one there.
    ext_set = EXT_IRQ_SRC & s_q.ext_mask & ~s_q.ext_ack;
    s_d.ext_flags = s_q.ext_flags;
    if (wsel(`EPC_IDX_EXT_FLAGS))
      s_d.ext_flags = s_d.ext_flags & ~wb[1:0];
    s_d.ext_flags = (s_d.ext_flags | ext_set) & EXT_IRQ_SRC & ~ack_nx;

    // Open-block flags: masked notification sets, write one clears
    ob_set = OPEN_BLOCK_NOTIFY & s_q.ob_mask;
    s_d.ob_flags = s_q.ob_flags;
    if (wsel(`EPC_IDX_OB_FLAGS))
      s_d.ob_flags = s_d.ob_flags & ~wb;
    s_d.ob_flags = s_d.ob_flags | ob_set;

    // Port change flags: masked group notification sets, write one clears
    pc_set = pc_notify & s_q.pc_mask;
    s_d.pc_flags = s_q.pc_flags;
    if (wsel(`EPC_IDX_PC_FLAGS))
      s_d.pc_flags = s_d.pc_flags & ~wb[5:0];
    s_d.pc_flags = s_d.pc_flags | pc_set;

    // Pin history; first sample after reset only primes it
    s_d.k_prev  = PORT_K_PINS;
    s_d.pl_prev = PORT_PL_PINS;
    s_d.prev_ok = 1'b1;

    // Sticky events: read clears, a new event in the same cycle survives
    if (rd_go && idx == `EPC_IDX_EVT_STATUS)
      s_d.evt_stat = 4'h0;
    s_d.evt_stat[1:0] = s_d.evt_stat[1:0] | (ext_set & ~s_q.ext_flags);
    s_d.evt_stat[`EPC_EVT_OB] = s_d.evt_stat[`EPC_EVT_OB] | (|ob_set);
    s_d.evt_stat[`EPC_EVT_PC] = s_d.evt_stat[`EPC_EVT_PC] | (|pc_set);
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Read data stands from the registered capture
  assign AVS_READDATA = s_q.rdata;
  // Requests are pure level gates so they drop the cycle either bit clears
  assign EXT_IRQ_REQ         = s_q.ext_flags & s_q.ext_ctrl;
  assign OPEN_BLOCK_IRQ_REQ  = s_q.ob_flags & s_q.ob_ctrl;
  assign PORT_CHANGE_IRQ_REQ = s_q.pc_flags & s_q.pc_ctrl;
  // Summary line for an external controller
  assign INT_OUT = |(s_q.evt_stat & s_q.evt_mask);

endmodule
`default_nettype wire

// ---- tb/epc_irq_top_monitor.sv ----
// Purpose: Port-level checks of the interrupt aggregation block
// Assumes: One clock, async active-low reset, one bus wait state
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module epc_irq_monitor (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [9:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [1:0]  EXT_IRQ_SRC,
  input wire logic [1:0]  EXT_IRQ_TAKEN,
  input wire logic [7:0]  OPEN_BLOCK_NOTIFY,
  input wire logic [31:0] PORT_K_PINS,
  input wire logic [1:0]  EXT_IRQ_REQ,
  input wire logic [7:0]  OPEN_BLOCK_IRQ_REQ,
  input wire logic [5:0]  PORT_CHANGE_IRQ_REQ
);
  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Write taken at this edge; the only cause for an open-block or port flag to drop
  logic wr_take;
  assign wr_take = AVS_WRITE & ~AVS_WAITREQUEST;
  ext_drop_a: assert property (1'b1 |=> (EXT_IRQ_REQ & ~$past(EXT_IRQ_SRC)) == 2'b00)
    else $error("ext request stayed after source dropped");
  ext_take_a: assert property (EXT_IRQ_TAKEN[0] && EXT_IRQ_REQ[0] |-> ##[1:2] !EXT_IRQ_REQ[0])
    else $error("ext request not blocked after delivery");
  ext_rise_a: assert property ($rose(EXT_IRQ_REQ[0]) |-> $past(EXT_IRQ_SRC[0]))
    else $error("ext request rose without source");
  ob_rise_a: assert property ((OPEN_BLOCK_IRQ_REQ & ~$past(OPEN_BLOCK_IRQ_REQ)
    & ~$past(OPEN_BLOCK_NOTIFY)) != 8'h00 |-> $past(wr_take))
    else $error("open-block request rose without cause");
  ob_fall_a: assert property ((~OPEN_BLOCK_IRQ_REQ & $past(OPEN_BLOCK_IRQ_REQ)) != 8'h00
    |-> $past(wr_take))
    else $error("open-block request fell without write");
  pc_fall_a: assert property ((~PORT_CHANGE_IRQ_REQ & $past(PORT_CHANGE_IRQ_REQ)) != 6'h00
    |-> $past(wr_take))
    else $error("port request fell without write");
  k_rise_a: assert property ($rose(PORT_CHANGE_IRQ_REQ[4]) |-> $past(wr_take)
    || $past(PORT_K_PINS) != $past(PORT_K_PINS, 2))
    else $error("k group request rose without pin change");
  pc_top_a: assert property (AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS[9:2]
    inside {8'h71, 8'h72, 8'h73} |-> AVS_READDATA[31:6] == 26'h0)
    else $error("port register upper bits not zero");
  bus_wait_a: assert property ($rose(AVS_READ || AVS_WRITE)
    |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus answer not after one wait cycle");
endmodule
bind epc_irq_top epc_irq_monitor u_mon (.CLK(CLK), .RST_N(RST_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .EXT_IRQ_SRC(EXT_IRQ_SRC), .EXT_IRQ_TAKEN(EXT_IRQ_TAKEN),
  .OPEN_BLOCK_NOTIFY(OPEN_BLOCK_NOTIFY), .PORT_K_PINS(PORT_K_PINS),
  .EXT_IRQ_REQ(EXT_IRQ_REQ), .OPEN_BLOCK_IRQ_REQ(OPEN_BLOCK_IRQ_REQ),
  .PORT_CHANGE_IRQ_REQ(PORT_CHANGE_IRQ_REQ));
`default_nettype wire

// ---- tb/epc_core_model.sv ----
// Purpose: Processor core side that takes extended interrupts
// Assumes: Requests are levels synchronous to the clock
// Notes:   Answers only while enabled, so tests can hold it off
`timescale 1ns/1ps
`default_nettype none
module epc_core_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        enable,
  input wire logic [1:0]  req,
  output logic [1:0]      taken
);
  // One-cycle delivery pulse per seen request; a pulse never repeats
  // back to back, which mirrors a core entering a handler once
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      taken <= 2'b00;
    else
      taken <= enable ? (req & ~taken) : 2'b00;
endmodule
`default_nettype wire

// ---- tb/extended_pin_change_irq_tb.sv ----
// Purpose: Register, extended, open-block and port-change scenarios
// Assumes: Bus answers after one wait state
// Notes:   Expected values come from the register rules only
`timescale 1ns/1ps
`default_nettype none
module extended_pin_change_irq_tb;
  logic clk = 0, rst_n = 0, rd = 0, wr_en = 0, core_en = 0, wait_rq, int_out;
  logic [9:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, k_pins = '0;
  logic [1:0]  ext_src = '0, taken, ext_req;
  logic [7:0]  ob_ntf = '0, pl_pins = '0, ob_req;
  logic [3:0]  pn = '0;
  logic [5:0]  pc_req;
  logic [31:0] q;
  int n_fail = 0, total_checks = 0, cyc = 0;
  logic [7:0] idx [16] = '{8'h61, 8'h62, 8'h63, 8'h65, 8'h66, 8'h67, 8'h6A, 8'h71,
    8'h72, 8'h73, 8'h8F, 8'h93, 8'h97, 8'h9B, 8'h9F, 8'h40};
  logic [7:0] rw_exp [16] = '{8'h03, 8'h00, 8'h03, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h3F,
    8'h00, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  epc_irq_top dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
    .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq), .EXT_IRQ_SRC(ext_src),
    .EXT_IRQ_TAKEN(taken), .OPEN_BLOCK_NOTIFY(ob_ntf), .PORT_A_NOTIFY(pn[0]),
    .PORT_E_NOTIFY(pn[1]), .PORT_G_NOTIFY(pn[2]), .PORT_J_NOTIFY(pn[3]),
    .PORT_K_PINS(k_pins), .PORT_PL_PINS(pl_pins), .EXT_IRQ_REQ(ext_req),
    .OPEN_BLOCK_IRQ_REQ(ob_req), .PORT_CHANGE_IRQ_REQ(pc_req), .INT_OUT(int_out));
  epc_core_model core (.clk(clk), .rst_n(rst_n), .enable(core_en), .req(ext_req),
    .taken(taken));
  // ---------------------------------------------------------------
  // Clock, timeout, shared tasks
  // ---------------------------------------------------------------
  initial
  begin
    forever #2 clk = ~clk;
  end
  // A hang counts as a mismatch and closes the run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic ck(input string nm, input logic [7:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, e, s);
    end
  endtask
  // Request held up to the rising edge at which waitrequest stands low; read
  // data is taken at that same edge and only then is the request released.
  // Waitrequest is watched mid-cycle, where it has settled for that edge.
  task automatic bus(input logic w, input logic [7:0] ix, d, output logic [31:0] r);
    @(posedge clk);
    addr <= {ix, 2'b00};
    wdata <= {24'h0, d};
    wr_en <= w;
    rd <= ~w;
    do @(negedge clk); while (wait_rq !== 1'b0);
    @(posedge clk);
    r = rdata;
    wr_en <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ix, d);
    bus(1'b1, ix, d, q);
  endtask
  task automatic rc(input logic [7:0] ix, e);
    bus(1'b0, ix, 8'h00, q);
    ck($sformatf("reg %h", ix), q[7:0], e);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (idx[i]) rc(idx[i], 8'h00);
    foreach (idx[i]) wr(idx[i], 8'hFF);
    foreach (idx[i]) rc(idx[i], rw_exp[i]);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h6A, 8'h00);
    $display("test registers done");
    wr(8'h61, 8'h03);
    wr(8'h63, 8'h01);
    ext_src <= 2'b11;
    rc(8'h62, 8'h01);
    @(negedge clk);
    ck("ext req", {6'h0, ext_req}, 8'h01);
    ck("int out masked", {7'h0, int_out}, 8'h00);
    wr(8'hA1, 8'h01);
    @(negedge clk);
    ck("int out", {7'h0, int_out}, 8'h01);
    rc(8'hA0, 8'h01);
    @(negedge clk);
    ck("int out cleared", {7'h0, int_out}, 8'h00);
    @(posedge clk);
    core_en <= 1'b1;
    repeat (6) @(posedge clk);
    core_en <= 1'b0;
    rc(8'h65, 8'h01);
    rc(8'h62, 8'h00);
    wr(8'h65, 8'h00);
    rc(8'h65, 8'h01);
    wr(8'h65, 8'h01);
    rc(8'h65, 8'h00);
    rc(8'h62, 8'h01);
    ext_src <= 2'b00;
    rc(8'h62, 8'h00);
    $display("test extended done");
    wr(8'h6A, 8'h0F);
    wr(8'h66, 8'hFF);
    ob_ntf <= 8'hFF;
    @(posedge clk);
    ob_ntf <= 8'h00;
    rc(8'h67, 8'h0F);
    wr(8'h66, 8'h05);
    @(negedge clk);
    ck("ob req", ob_req, 8'h05);
    wr(8'h67, 8'h01);
    rc(8'h67, 8'h0E);
    @(negedge clk);
    ck("ob req", ob_req, 8'h04);
    $display("test open block done");
    wr(8'h73, 8'h3E);
    wr(8'h71, 8'h3F);
    wr(8'h93, 8'h01);
    wr(8'h8F, 8'h80);
    pn <= 4'hF;
    k_pins <= 32'h8000_0000;
    @(posedge clk);
    pn <= 4'h0;
    rc(8'h72, 8'h0E);
    k_pins <= 32'h8000_0001;
    pl_pins <= 8'h80;
    rc(8'h72, 8'h3E);
    bus(1'b0, 8'h73, 8'h00, q);
    wr(8'h73, q[7:0] | 8'h01);
    pn <= 4'h1;
    @(posedge clk);
    pn <= 4'h0;
    rc(8'h72, 8'h3F);
    @(negedge clk);
    ck("pc req", {2'b00, pc_req}, 8'h3F);
    wr(8'h72, 8'h3F);
    rc(8'h72, 8'h00);
    $display("test port change done");
    summarize();
  end
endmodule
`default_nettype wire
